// [sleep_ctrl.sv]
// Sleep entry and wake-up sequencing from the speed command input.
// Assumes pin comparator levels arrive synchronous to clk_in and the core
// supply regulator reports good with core_supply_good_in.
`timescale 1ns/10ps
`include "sleep_cfg.svh"
module sleep_ctrl #(
  parameter int unsigned SLEEP_DLY_00_CYC = `MS_TO_CYC(`SLEEP_DLY_00_MS),
  parameter int unsigned SLEEP_DLY_01_CYC = `MS_TO_CYC(`SLEEP_DLY_01_MS),
  parameter int unsigned SLEEP_DLY_10_CYC = `MS_TO_CYC(`SLEEP_DLY_10_MS),
  parameter int unsigned SLEEP_DLY_11_CYC = `MS_TO_CYC(`SLEEP_DLY_11_MS),
  parameter int unsigned SUPPLY_MAX_CYC   = `MS_TO_CYC(`SUPPLY_MAX_MS)
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic [31:0]      rd_data_out,
  input  wire logic        below_sleep_entry_level_in,
  input  wire logic        above_sleep_exit_level_in,
  input  wire logic        speed_pin_in,
  input  wire logic        core_supply_good_in,
  output logic             core_logic_supply_en_out,
  output logic             motor_drive_en_out,
  output logic             asleep_out
);

  sleep_pkg::sleep_state_e state_r;
  sleep_pkg::sleep_state_e state_nxt;
  sleep_pkg::ctrl_s        ctrl_r;
  sleep_pkg::bus_req_s     req;
  logic [31:0]             rd_data_r;
  logic [31:0]             supply_cnt_r;
  logic                    supply_late_r;
  logic                    supply_en_r;
  logic                    drive_en_r;
  logic                    asleep_r;
  logic                    qual_done;

  function automatic logic [31:0] dly_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: dly_cycles = SLEEP_DLY_00_CYC[31:0];
      2'h1: dly_cycles = SLEEP_DLY_01_CYC[31:0];
      2'h2: dly_cycles = SLEEP_DLY_10_CYC[31:0];
      2'h3: dly_cycles = SLEEP_DLY_11_CYC[31:0];
    endcase
  endfunction : dly_cycles

  assign req = '{addr: addr_in, wdata: wr_data_in, wr: wr_en_in, rd: rd_en_in};

  wire is_analog  = (ctrl_r.mode == `MODE_ANALOG);
  wire is_digital = (ctrl_r.mode == `MODE_DIGITAL);
  // Pulse modes sample the pin as a plain level; a wave at 3 Hz..32767 Hz
  // has lows of up to about 167 ms, shorter than only the 200 ms qualification delay
  wire pin_low    = !speed_pin_in;

  wire sleep_cond = is_analog  ? below_sleep_entry_level_in :
                    is_digital ? !ctrl_r.dig_cmd :
                                 pin_low;
  wire wake_cond  = is_analog  ? above_sleep_exit_level_in :
                    is_digital ? ctrl_r.dig_cmd :
                                 speed_pin_in;

  // The motor stays driven while a sleep request is being qualified
  function automatic logic is_driving(input sleep_pkg::sleep_state_e st);
    is_driving = (st == sleep_pkg::ST_ACTIVE) || (st == sleep_pkg::ST_QUAL);
  endfunction : is_driving

  wire in_wait    = is_driving(state_r);
  wire qual_run   = in_wait && sleep_cond && !is_digital;
  wire st_wake    = (state_r == sleep_pkg::ST_WAKE);

  // Digital mode bypasses the timer: a cleared command bit stops at once
  qual_timer u_qual_timer (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .run_in   (qual_run),
    .limit_in (dly_cycles(ctrl_r.dly_sel)),
    .done_out (qual_done)
  );

  wire sleep_go = is_digital ? (in_wait && sleep_cond) : qual_done;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sleep_pkg::ST_ACTIVE: begin
        if (sleep_go) begin
          state_nxt = sleep_pkg::ST_SLEEP;
        end else if (sleep_cond) begin
          state_nxt = sleep_pkg::ST_QUAL;
        end
      end
      sleep_pkg::ST_QUAL: begin
        if (sleep_go) begin
          state_nxt = sleep_pkg::ST_SLEEP;
        end else if (!sleep_cond) begin
          state_nxt = sleep_pkg::ST_ACTIVE;
        end
      end
      sleep_pkg::ST_SLEEP: begin
        if (wake_cond) begin
          state_nxt = sleep_pkg::ST_WAKE;
        end
      end
      sleep_pkg::ST_WAKE: begin
        if (core_supply_good_in) begin
          state_nxt = sleep_pkg::ST_START;
        end
      end
      sleep_pkg::ST_START: begin
        state_nxt = sleep_pkg::ST_ACTIVE;
      end
      default: begin
        state_nxt = sleep_pkg::ST_SLEEP;
      end
    endcase
  end

  wire supply_nxt = (state_nxt != sleep_pkg::ST_SLEEP);
  wire drive_nxt  = is_driving(state_nxt);
  wire asleep_nxt = (state_nxt == sleep_pkg::ST_SLEEP);

  // Watch for a regulator that misses its wake-up window
  wire        supply_miss    = st_wake &&
                               (supply_cnt_r >= SUPPLY_MAX_CYC[31:0]);
  wire [31:0] supply_cnt_nxt = st_wake ? supply_cnt_r + 32'h0000_0001
                                       : 32'h0000_0000;

  // Register decode, shared by the write and the read path
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    addr_hit = (addr == reg_addr);
  endfunction : addr_hit

  wire       ctrl_hit   = addr_hit(req.addr, `ADDR_CTRL);
  wire       status_hit = addr_hit(req.addr, `ADDR_STATUS);
  wire       wr_ctrl    = req.wr && ctrl_hit;
  wire       late_clr   = req.wr && status_hit && req.wdata[5];
  wire [5:0] ctrl_nxt   = req.wdata[5:0];

  // Reset lands in WAKE: supply on, drive held off until the supply is good
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= sleep_pkg::ST_WAKE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Supply stays on in every state but sleep
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      supply_en_r <= 1'b1;
    end else begin
      supply_en_r <= supply_nxt;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_en_r <= 1'b0;
    end else begin
      drive_en_r <= drive_nxt;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      asleep_r <= 1'b0;
    end else begin
      asleep_r <= asleep_nxt;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      supply_cnt_r <= 32'h0000_0000;
    end else begin
      supply_cnt_r <= supply_cnt_nxt;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      supply_late_r <= 1'b0;
    end else if (supply_miss) begin
      supply_late_r <= 1'b1;
    end else if (late_clr) begin
      supply_late_r <= 1'b0;
    end
  end

  // Status word: sticky late flag above the one-hot state
  wire [31:0] ctrl_word = {26'h000_0000, ctrl_r};
  wire [31:0] stat_word = {26'h000_0000, supply_late_r, state_r};
  wire [31:0] rd_sel    = ctrl_hit   ? ctrl_word :
                          status_hit ? stat_word : 32'h0000_0000;
  // Read data fall back to zero outside the answer cycle
  wire [31:0] rd_nxt    = req.rd ? rd_sel : 32'h0000_0000;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= sleep_pkg::ctrl_s'(6'(`CTRL_RESET));
    end else if (wr_ctrl) begin
      ctrl_r <= sleep_pkg::ctrl_s'(ctrl_nxt);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_r <= 32'h0000_0000;
    end else begin
      rd_data_r <= rd_nxt;
    end
  end

  // Outputs come straight from their flip-flops
  assign rd_data_out              = rd_data_r;
  assign core_logic_supply_en_out = supply_en_r;
  assign motor_drive_en_out       = drive_en_r;
  assign asleep_out               = asleep_r;

endmodule : sleep_ctrl

// [sleep_cfg.svh]
// Constants of the speed-pin sleep controller: offsets, fields, resets, times.
// Assumes a 200 MHz core clock; times are turned into cycle counts below.
// How it works
// - Analog mode: pin at or below 40 mV is a sleep request.
// - Analog mode: pin at or above 2.2 V is a wake request.
// - Analog or PWM mode: wake level recognised within 1.5 us.
// - Core logic supply available within 5 ms after a valid wake level.
// - First output PWM pulse within 30 ms or 180 ms after supply is available.
// - Sleep request qualified for 0.05, 0.2, 20 or 200 ms by delay field.
// - PWM or frequency mode: low pin held for the delay is a sleep request.
// - Motor drive stops within 2 ms after a qualified sleep request.
// - Frequency mode accepts a square wave from 3 Hz to 32767 Hz; the code takes any low half longer than the delay as a sleep request.
// - Mode 10b is digital command; a cleared speed command bit requests stop.
`ifndef SLEEP_CFG_SVH
`define SLEEP_CFG_SVH

`define ADDR_CTRL          8'h00
`define ADDR_STATUS        8'h04

`define CTRL_MODE_LSB      0
`define CTRL_DLY_LSB       2
`define CTRL_DIG_CMD_BIT   4
`define CTRL_EXT_BIT       5
`define CTRL_RESET         32'h0000_0000

`define MODE_ANALOG        2'h0
`define MODE_PWM           2'h1
`define MODE_DIGITAL       2'h2
`define MODE_FREQ          2'h3

`define CLK_PERIOD_NS      5.0
`define SLEEP_DLY_00_MS    0.05
`define SLEEP_DLY_01_MS    0.2
`define SLEEP_DLY_10_MS    20.0
`define SLEEP_DLY_11_MS    200.0
`define WAKE_DET_MAX_US    1.5
`define SUPPLY_MAX_MS      5.0
`define DRIVE_STD_MAX_MS   30.0
`define DRIVE_EXT_MAX_MS   180.0
`define STOP_MAX_MS        2.0
`define FREQ_MIN_HZ        3
`define FREQ_MAX_HZ        32767

`define MS_TO_CYC(t)       (int'((t) * 1.0e6 / `CLK_PERIOD_NS))
`define WAKE_DET_MAX_CYC   (int'(`WAKE_DET_MAX_US * 1.0e3 / `CLK_PERIOD_NS))

`endif

// [sleep_pkg.sv]
// Types of the sleep controller: one-hot states, control fields, bus request.
// Assumes sleep_cfg.svh supplies the numeric constants.
package sleep_pkg;

  typedef enum logic [4:0] {
    ST_ACTIVE = 5'b00001,
    ST_QUAL   = 5'b00010,
    ST_SLEEP  = 5'b00100,
    ST_WAKE   = 5'b01000,
    ST_START  = 5'b10000
  } sleep_state_e;

  typedef struct packed {
    logic       ext_variant;
    logic       dig_cmd;
    logic [1:0] dly_sel;
    logic [1:0] mode;
  } ctrl_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

endpackage : sleep_pkg

// [qual_timer.sv]
// Qualification counter: counts while run is high and holds at the limit, clears when it drops.
// Assumes limit stays stable while run is high.
`timescale 1ns/10ps
module qual_timer (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  input  wire logic [31:0] limit_in,
  output logic             done_out
);

  logic [31:0] count_r;
  logic [31:0] count_nxt;
  wire         at_limit = (count_r >= limit_in);

  // Any break in the condition clears the count
  assign count_nxt = !run_in ? 32'h0000_0000 :
                     at_limit ? count_r : count_r + 32'h0000_0001;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_r <= 32'h0000_0000;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign done_out = run_in && at_limit;

endmodule : qual_timer

// [sleep_ctrl_monitor.sv]
// Port checker of sleep_ctrl: CTRL shadow, sleep count, sleep and wake timing.
// Assumes CTRL changes only by port writes and never while a sleep condition is held.
`timescale 1ns/10ps
module sleep_ctrl_monitor #(
  parameter int unsigned D0 = 8,
  parameter int unsigned D1 = 16,
  parameter int unsigned D2 = 32,
  parameter int unsigned D3 = 64
) (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [31:0] rd_data_out,
  input wire logic        below_sleep_entry_level_in,
  input wire logic        above_sleep_exit_level_in,
  input wire logic        speed_pin_in,
  input wire logic        core_supply_good_in,
  input wire logic        core_logic_supply_en_out,
  input wire logic        motor_drive_en_out,
  input wire logic        asleep_out
);
  logic [5:0]  ctrl_r;
  logic [31:0] cnt_r;
  wire  [1:0]  mode = ctrl_r[1:0];
  wire         dig  = mode == 2'h2;
  wire  [31:0] lim  = ctrl_r[3] ? (ctrl_r[2] ? D3 : D2) : (ctrl_r[2] ? D1 : D0);
  wire         slp  = mode == 2'h0 ? below_sleep_entry_level_in : !dig && !speed_pin_in;
  wire         wak  = mode == 2'h0 ? above_sleep_exit_level_in : speed_pin_in;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= 6'h00;
      cnt_r  <= 32'h0000_0000;
    end else begin
      if (wr_en_in && addr_in == 8'h00) ctrl_r <= wr_data_in[5:0];
      cnt_r <= slp ? cnt_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_sleep_not_early: assert property (
    $rose(asleep_out) && !dig |-> cnt_r >= lim) else $error("sleep too early");
  a_sleep_in_time: assert property (
    cnt_r == lim + 4 |-> asleep_out) else $error("sleep too late");
  a_sleep_outputs_off: assert property (
    asleep_out |-> !motor_drive_en_out && !core_logic_supply_en_out) else $error("drive on");
  a_digital_stop: assert property (
    dig && !ctrl_r[4] && motor_drive_en_out |=> !motor_drive_en_out) else $error("no stop");
  a_wake_fast: assert property (
    asleep_out && wak && mode < 2'h2 |=> !asleep_out && core_logic_supply_en_out)
    else $error("wake slow");
  a_drive_after_good: assert property (
    core_supply_good_in && core_logic_supply_en_out && !motor_drive_en_out && !asleep_out
    |-> ##[1:3] motor_drive_en_out) else $error("drive late");
  a_read_idle_zero: assert property (
    !$past(rd_en_in) |-> rd_data_out == 32'h0000_0000) else $error("read data stray");
  a_ctrl_read_back: assert property (
    $past(rd_en_in) && $past(addr_in) == 8'h00 |-> rd_data_out == {26'h000_0000,
    $past(ctrl_r)}) else $error("ctrl read wrong");
endmodule : sleep_ctrl_monitor

// [speed_host_model.sv]
// Host side of the speed pin: analog level in mV, logic level or square wave.
// Assumes the bench changes the level and half period by clocked assignment.
`timescale 1ns/10ps
module speed_host_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] mv_in,
  input  wire logic [15:0] half_in,
  output logic             below_out,
  output logic             above_out,
  output logic             pin_out = 1'b0
);
  logic [15:0] ph_r = 16'h0000;
  assign below_out = mv_in <= 16'd40;
  assign above_out = mv_in >= 16'd2200;
  // Zero half period holds a level, else a 50% square wave
  always_ff @(posedge clk_in) begin
    ph_r <= (half_in == 16'h0000 || ph_r >= half_in - 1) ? 16'h0000 : ph_r + 16'h0001;
    if (half_in == 16'h0000) pin_out <= mv_in > 16'd1650;
    else if (ph_r >= half_in - 1) pin_out <= !pin_out;
  end
endmodule : speed_host_model

// [speed_pin_sleep_control_bench.sv]
// Bench of sleep_ctrl: host pin model, slow supply regulator, port bus.
// Assumes the monitor and host model files are compiled first.
`timescale 1ns/10ps
module speed_pin_sleep_control_bench;
  localparam int D[4] = '{8, 16, 32, 64};
  logic        clk_in = 1'b0, rst_in = 1'b1, wr_en_in = 1'b0, rd_en_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0000_0000;
  logic [15:0] mv = 16'd3300, half = 16'h0000;
  logic [4:0]  good_sh = 5'h00;
  wire  [31:0] rd_data_out;
  wire         below, above, pin, sup_en, drv_en, asleep;
  int          n_fail = 0, checks_done = 0;
  always #2.5 clk_in = !clk_in;
  // Supply reports good five cycles after it is enabled
  always @(posedge clk_in) good_sh <= rst_in ? 5'h00 : {good_sh[3:0], sup_en};
  speed_host_model u_host (.clk_in, .mv_in(mv), .half_in(half), .below_out(below),
    .above_out(above), .pin_out(pin));
  sleep_ctrl #(.SLEEP_DLY_00_CYC(8), .SLEEP_DLY_01_CYC(16), .SLEEP_DLY_10_CYC(32),
    .SLEEP_DLY_11_CYC(64), .SUPPLY_MAX_CYC(50)) u_dut (.clk_in, .rst_in, .addr_in,
    .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .below_sleep_entry_level_in(below),
    .above_sleep_exit_level_in(above), .speed_pin_in(pin), .core_supply_good_in(good_sh[4]),
    .core_logic_supply_en_out(sup_en), .motor_drive_en_out(drv_en), .asleep_out(asleep));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_en_in   <= 1'b1;
    addr_in    <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_in);
    rd_en_in <= 1'b1;
    addr_in  <= a;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1 chk(what, exp, rd_data_out);
  endtask : rd
  // Waits for asleep (sel 0) or drive (sel 1); a used-up bound ends the run
  task automatic await(input bit sel, input int lim, output int n);
    n = 0;
    while ((sel ? drv_en : asleep) !== 1'b1) begin
      @(posedge clk_in);
      #1 n++;
      if (n > lim) begin
        n_fail++;
        $display("BAD wait sel %0d exp %0d got %0d", sel, lim, n);
        report_and_stop();
      end
    end
  endtask : await
  task automatic sleep_wake(input logic [1:0] m, input logic [1:0] s, input logic [15:0] lo,
                            input logic [15:0] hi);
    int n;
    wr(8'h00, {26'h000_0000, 2'b01, s, m});
    @(posedge clk_in);
    mv <= lo;
    await(0, D[s] + 10, n);
    chk("sleep delay", 1, n >= D[s] && n <= D[s] + 4);
    chk("drive off", 0, drv_en);
    repeat (10) @(posedge clk_in);
    mv <= hi;
    // Pulse modes pass the level through the host's pin register first
    repeat (2) @(posedge clk_in);
    #1 chk("woken", 0, asleep);
    chk("supply on", 1, sup_en);
    await(1, 30, n);
  endtask : sleep_wake
  task automatic t_power_up();
    int n;
    #1 chk("reset supply", 1, sup_en);
    chk("reset drive", 0, drv_en);
    await(1, 20, n);
    rd(8'h00, 32'h0000_0000, "ctrl reset");
    rd(8'h04, 32'h0000_0001, "status active");
    rd(8'h08, 32'h0000_0000, "unmapped");
    $display("t_power_up done");
  endtask : t_power_up
  task automatic t_analog();
    for (int s = 0; s < 4; s++) sleep_wake(2'h0, s[1:0], 16'd40, 16'd2200);
    $display("t_analog done");
  endtask : t_analog
  task automatic t_pwm_restart();
    wr(8'h00, 32'h0000_0015);
    mv <= 16'd0;
    repeat (12) @(posedge clk_in);
    mv <= 16'd3300;
    @(posedge clk_in);
    mv <= 16'd0;
    repeat (12) @(posedge clk_in);
    mv <= 16'd3300;
    #1 chk("restart awake", 0, asleep);
    sleep_wake(2'h1, 2'h1, 16'd0, 16'd3300);
    $display("t_pwm_restart done");
  endtask : t_pwm_restart
  task automatic t_freq();
    wr(8'h00, 32'h0000_0013);
    half <= 16'd6;
    repeat (100) @(posedge clk_in);
    half <= 16'd0;
    #1 chk("wave awake", 0, asleep);
    sleep_wake(2'h3, 2'h0, 16'd0, 16'd3300);
    $display("t_freq done");
  endtask : t_freq
  task automatic t_digital();
    int n;
    wr(8'h00, 32'h0000_0032);
    wr(8'h00, 32'h0000_0002);
    await(0, 4, n);
    rd(8'h00, 32'h0000_0002, "ctrl digital");
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 chk("rerun awake", 0, asleep);
    await(1, 20, n);
    rd(8'h00, 32'h0000_0000, "ctrl rerun");
    $display("t_digital done");
  endtask : t_digital
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    t_power_up();
    t_analog();
    t_pwm_restart();
    t_freq();
    t_digital();
    report_and_stop();
  end
endmodule : speed_pin_sleep_control_bench
bind sleep_ctrl sleep_ctrl_monitor #(.D0(SLEEP_DLY_00_CYC), .D1(SLEEP_DLY_01_CYC),
  .D2(SLEEP_DLY_10_CYC), .D3(SLEEP_DLY_11_CYC)) u_mon (.clk_in, .rst_in, .addr_in,
  .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .below_sleep_entry_level_in,
  .above_sleep_exit_level_in, .speed_pin_in, .core_supply_good_in,
  .core_logic_supply_en_out, .motor_drive_en_out, .asleep_out);
